// ---- hdl/ccg_regs.vh ----
// constants for the counter gate generator: register map, fields, counts
`ifndef CCG_REGS_VH
`define CCG_REGS_VH

// ==========================================================
// register offsets (byte addresses, low 8 address bits)
`define CCG_OFS_CTRL 8'h00
`define CCG_OFS_CMD 8'h04
`define CCG_OFS_STATUS 8'h08
`define CCG_OFS_COUNT 8'h0C

// ==========================================================
// control register fields and reset value
`define CCG_CTRL_REFINT 0
`define CCG_CTRL_CODE_LSB 1
`define CCG_CTRL_CODE_MSB 3
`define CCG_CTRL_RESET 32'h00000003
`define CCG_CTRL_RESET_REFINT 1'b1
`define CCG_CTRL_RESET_CODE 3'h1

// ==========================================================
// command register bits (write one, self clearing)
`define CCG_CMD_INIT 0
`define CCG_CMD_START 1
`define CCG_CMD_RELEASE 2
`define CCG_CMD_SRST 3

// ==========================================================
// status register bits
`define CCG_STS_GATE 0
`define CCG_STS_ARM 1
`define CCG_STS_CTL 2
`define CCG_STS_TERM 3
`define CCG_STS_START 4
`define CCG_STS_DONE 5

// ==========================================================
// reference prescaler: 10 MHz reference edges per 100 kHz period
`define CCG_REF_DIV 7'h64
`define CCG_REF_HALF 7'h32

// ==========================================================
// gate time codes and divide ratios in 100 kHz clocks
`define CCG_CODE_100US 3'h1
`define CCG_CODE_1MS 3'h2
`define CCG_CODE_10MS 3'h3
`define CCG_CODE_100MS 3'h4
`define CCG_CODE_1S 3'h5
`define CCG_RATIO_100US 17'h0000A
`define CCG_RATIO_1MS 17'h00064
`define CCG_RATIO_10MS 17'h003E8
`define CCG_RATIO_100MS 17'h02710
`define CCG_RATIO_1S 17'h186A0

// ==========================================================
// bus responses
`define CCG_RESP_OKAY 2'h0
`define CCG_RESP_SLVERR 2'h2

`endif

// ---- hdl/ccg_rate_div.v ----
// edge-counting divider: rise and fall pulses plus a square level
`timescale 1ns/100ps
`default_nettype none

module ccg_rate_div #(
  parameter [6:0] DIV = 7'h64,
  parameter [6:0] HALF = 7'h32
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // input event
  input wire i_en,
  // divided outputs
  output reg o_rise,
  output reg o_fall,
  output reg o_level
);

  reg [6:0] cnt_q;

  // ==========================================================
  // counter and derived edges
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 7'h00;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
      o_level <= 1'b0;
    end else begin
      o_rise <= 1'b0;
      o_fall <= 1'b0;
      if (i_en) begin
        if (cnt_q == DIV - 7'h01) begin
          cnt_q <= 7'h00;
          o_rise <= 1'b1;
          o_level <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 7'h01;
          if (cnt_q == HALF - 7'h01) begin
            o_fall <= 1'b1;
            o_level <= 1'b0;
          end
        end
      end
    end
  end

endmodule // ccg_rate_div

`default_nettype wire

// ---- hdl/ccg_gate_gen.v ----
// counter gate generator: reference select, prescaler, gate timing, bus slave
//
// Function
// R1: prescaler divides selected reference by 100
// R2: 50 kHz from inverted 100 kHz, toggled
// R3: select high uses internal reference, drives out
// R4: select low disables internal, uses external
// R5: three-bit code picks ratio ten to 1e5
// R6: gate flop on 100 kHz, enables only
// R7: idle: control flag clear, divider free-runs
// R8: control flag set clears arm, divider
// R9: first clock after init clears gate flop
// R10: host starts by briefly clearing control flag
// R11: next clock sets arm flag
// R12: following clock opens gate, divider counts
// R13: divider terminal high after half count
// R14: terminal count sets control, clears arm
// R15: next clock closes gate, exact count
// R16: host clears control flag, divider free-runs
// R17: soft reset clears flags, gate closed
// R18: gate active high between open, close
`timescale 1ns/100ps
`default_nettype none
`include "ccg_regs.vh"

module ccg_gate_gen (
  // clock and reset
  input wire i_clk,
  input wire i_sys_rst,
  // reference inputs, synchronous levels
  input wire i_int_ref,
  input wire i_ext_ref,
  // reference output and derived clocks
  output reg o_ref_out,
  output reg o_ref_out_en,
  output reg o_clk_100k,
  output reg o_clk_50k,
  // gate to the count chain
  output reg o_gate,
  // axi4-lite write address
  input wire i_s_axi_awvalid,
  output reg o_s_axi_awready,
  input wire [7:0] i_s_axi_awaddr,
  input wire [2:0] i_s_axi_awprot,
  // axi4-lite write data
  input wire i_s_axi_wvalid,
  output reg o_s_axi_wready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  // axi4-lite write response
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  output reg [1:0] o_s_axi_bresp,
  // axi4-lite read address
  input wire i_s_axi_arvalid,
  output reg o_s_axi_arready,
  input wire [7:0] i_s_axi_araddr,
  input wire [2:0] i_s_axi_arprot,
  // axi4-lite read data
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp
);

  // ==========================================================
  // declarations
  reg ref_int_q;
  reg [2:0] code_q;
  reg ref_prev_q;
  reg ctl_q;
  reg arm_q;
  reg start_q;
  reg done_q;
  reg [16:0] cnt_q;
  reg [16:0] ratio;
  reg aw_full_q;
  reg w_full_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [31:0] rd_mux;
  reg rd_hit;
  wire ref_sel;
  wire ref_edge;
  wire tick_100k;
  wire fall_100k;
  wire level_100k;
  wire [16:0] last_cnt;
  wire term_lvl;
  wire term_evt;
  wire wr_do;
  wire wr_ctrl;
  wire wr_cmd;
  wire cmd_init;
  wire cmd_start;
  wire cmd_release;
  wire cmd_srst;
  wire start_ok;
  wire [31:0] status_word;

  // ==========================================================
  // reference source selection
  assign ref_sel = ref_int_q ? i_int_ref : i_ext_ref; // [R3] [R4]
  assign ref_edge = ref_sel & ~ref_prev_q;

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ref_prev_q <= 1'b0;
      o_ref_out <= 1'b0;
      o_ref_out_en <= 1'b0;
    end else begin
      ref_prev_q <= ref_sel;
      o_ref_out <= ref_int_q & i_int_ref; // [R3] [R4]
      o_ref_out_en <= ref_int_q; // [R3] [R4]
    end
  end

  // ==========================================================
  // reference prescaler, one pulse per 100 reference edges
  ccg_rate_div #(
    .DIV(`CCG_REF_DIV),
    .HALF(`CCG_REF_HALF)
  ) u_reference_prescaler (
    .i_clk(i_clk),
    .i_rst(i_sys_rst),
    .i_en(ref_edge), // [R1]
    .o_rise(tick_100k),
    .o_fall(fall_100k),
    .o_level(level_100k)
  );

  // ==========================================================
  // derived clock outputs
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_clk_100k <= 1'b0;
      o_clk_50k <= 1'b0;
    end else begin
      o_clk_100k <= level_100k; // [R1]
      // half-rate toggle on the rise of the inverted clock
      if (fall_100k) begin
        o_clk_50k <= ~o_clk_50k; // [R2]
      end
    end
  end

  // ==========================================================
  // gate time ratio and divider terminal
  always @* begin
    case (code_q) // [R5]
      `CCG_CODE_100US: ratio = `CCG_RATIO_100US;
      `CCG_CODE_1MS: ratio = `CCG_RATIO_1MS;
      `CCG_CODE_10MS: ratio = `CCG_RATIO_10MS;
      `CCG_CODE_100MS: ratio = `CCG_RATIO_100MS;
      `CCG_CODE_1S: ratio = `CCG_RATIO_1S;
      default: ratio = `CCG_RATIO_100US;
    endcase
  end

  assign last_cnt = ratio - 17'h00001;
  assign term_lvl = (cnt_q >= {1'b0, ratio[16:1]}); // [R13]
  assign term_evt = tick_100k & arm_q & o_gate & (cnt_q == last_cnt); // [R14]

  // ==========================================================
  // register write decode
  assign wr_do = aw_full_q & w_full_q & ~o_s_axi_bvalid;
  assign wr_ctrl = wr_do & (awaddr_q[7:2] == `CCG_OFS_CTRL >> 2);
  assign wr_cmd = wr_do & (awaddr_q[7:2] == `CCG_OFS_CMD >> 2) & wstrb_q[0];
  assign cmd_init = wr_cmd & wdata_q[`CCG_CMD_INIT];
  assign cmd_start = wr_cmd & wdata_q[`CCG_CMD_START];
  assign cmd_release = wr_cmd & wdata_q[`CCG_CMD_RELEASE];
  assign cmd_srst = wr_cmd & wdata_q[`CCG_CMD_SRST];
  // a start pulse only counts while the control flag is set and the gate is not armed
  assign start_ok = cmd_start & ctl_q & ~arm_q & ~cmd_init; // [R10]

  // ==========================================================
  // control register
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ref_int_q <= `CCG_CTRL_RESET_REFINT;
      code_q <= `CCG_CTRL_RESET_CODE;
    end else if (wr_ctrl && wstrb_q[0]) begin
      ref_int_q <= wdata_q[`CCG_CTRL_REFINT];
      code_q <= wdata_q[`CCG_CTRL_CODE_MSB:`CCG_CTRL_CODE_LSB];
    end
  end

  // ==========================================================
  // gate control flag
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctl_q <= 1'b0;
    end else if (cmd_srst) begin
      ctl_q <= 1'b0; // [R17]
    end else if (term_evt || cmd_init) begin
      ctl_q <= 1'b1; // [R8] [R14]
    end else if (start_ok || cmd_release) begin
      ctl_q <= 1'b0; // [R10] [R16] [R7]
    end
  end

  // ==========================================================
  // start pending, held until the next 100 kHz clock
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      start_q <= 1'b0;
    end else if (cmd_srst || cmd_init) begin
      start_q <= 1'b0;
    end else if (start_ok) begin
      start_q <= 1'b1;
    end else if (tick_100k) begin
      start_q <= 1'b0;
    end
  end

  // ==========================================================
  // gate arm flag
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      arm_q <= 1'b0;
    end else if (cmd_srst) begin
      arm_q <= 1'b0; // [R17]
    end else if (ctl_q || cmd_init || term_evt) begin
      arm_q <= 1'b0; // [R8] [R14]
    end else if (tick_100k && start_q) begin
      arm_q <= 1'b1; // [R11]
    end
  end

  // ==========================================================
  // gate output flop, moves only on the 100 kHz clock or a soft reset
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_gate <= 1'b0;
    end else if (cmd_srst) begin
      o_gate <= 1'b0; // [R17]
    end else if (tick_100k) begin // [R6]
      if (arm_q && !o_gate) begin
        o_gate <= 1'b1; // [R12] [R18]
      end else if (!arm_q) begin
        o_gate <= 1'b0; // [R9] [R15] [R18]
      end
    end
  end

  // ==========================================================
  // gate time divider
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q <= 17'h00000;
    end else if (cmd_srst || cmd_init || ctl_q || start_q) begin
      cnt_q <= 17'h00000; // [R8] [R17]
    end else if (tick_100k) begin
      if (arm_q && !o_gate) begin
        cnt_q <= 17'h00001; // [R12]
      end else if (arm_q) begin
        cnt_q <= term_evt ? 17'h00000 : cnt_q + 17'h00001; // [R15]
      end else if (cnt_q >= last_cnt) begin
        cnt_q <= 17'h00000; // [R7]
      end else begin
        cnt_q <= cnt_q + 17'h00001; // [R7]
      end
    end
  end

  // ==========================================================
  // sticky done: set by the closing clock, cleared by init
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      done_q <= 1'b0;
    end else if (tick_100k && !arm_q && o_gate) begin
      done_q <= 1'b1;
    end else if (cmd_init || cmd_srst) begin
      done_q <= 1'b0;
    end
  end

  // ==========================================================
  // axi4-lite write channels
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready <= 1'b1;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `CCG_RESP_OKAY;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (o_s_axi_awready && i_s_axi_awvalid) begin
        o_s_axi_awready <= 1'b0;
        aw_full_q <= 1'b1;
        awaddr_q <= i_s_axi_awaddr;
      end
      if (o_s_axi_wready && i_s_axi_wvalid) begin
        o_s_axi_wready <= 1'b0;
        w_full_q <= 1'b1;
        wdata_q <= i_s_axi_wdata;
        wstrb_q <= i_s_axi_wstrb;
      end
      if (wr_do) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        if (awaddr_q[7:2] <= `CCG_OFS_COUNT >> 2) begin
          o_s_axi_bresp <= `CCG_RESP_OKAY;
        end else begin
          o_s_axi_bresp <= `CCG_RESP_SLVERR;
        end
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // read data selection
  assign status_word = {26'h0000000, done_q, start_q, term_lvl, ctl_q, arm_q, o_gate};

  always @* begin
    rd_hit = 1'b1;
    case (i_s_axi_araddr[7:2])
      `CCG_OFS_CTRL >> 2: rd_mux = {28'h0000000, code_q, ref_int_q};
      `CCG_OFS_CMD >> 2: rd_mux = 32'h00000000;
      `CCG_OFS_STATUS >> 2: rd_mux = status_word;
      `CCG_OFS_COUNT >> 2: rd_mux = {15'h0000, cnt_q};
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // axi4-lite read channels
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h00000000;
      o_s_axi_rresp <= `CCG_RESP_OKAY;
    end else begin
      if (o_s_axi_arready && i_s_axi_arvalid) begin
        o_s_axi_arready <= 1'b0;
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata <= rd_mux;
        o_s_axi_rresp <= rd_hit ? `CCG_RESP_OKAY : `CCG_RESP_SLVERR;
      end
      if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
        o_s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // ccg_gate_gen

`default_nettype wire

// ---- tb/ccg_gate_gen_asserts.sv ----
// concurrent checks on the counter gate generator ports
`timescale 1ns/100ps
`default_nettype none
module ccg_gate_gen_asserts (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // watched single-bit signals
  input wire logic i_int_ref,
  i_ext_ref,
  i_s_axi_awvalid,
  i_s_axi_wvalid,
  i_s_axi_bready,
  i_s_axi_arvalid,
  o_ref_out,
  o_ref_out_en,
  o_clk_100k,
  o_clk_50k,
  o_gate,
  o_s_axi_awready,
  o_s_axi_wready,
  o_s_axi_bvalid,
  o_s_axi_arready,
  o_s_axi_rvalid,
  // write response code
  input wire logic [1:0] o_s_axi_bresp
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ==========================================================
  // selected-reference edges per prescaler period
  logic c_q, s_q, e_q;
  logic [1:0] sw_q;
  logic [7:0] n_q;
  wire sref = o_ref_out_en ? i_int_ref : i_ext_ref;
  wire up = o_clk_100k & ~c_q;
  wire hit = sref & ~s_q;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      c_q <= 1'b0;
      s_q <= 1'b0;
      e_q <= 1'b0;
      sw_q <= 2'h2;
      n_q <= 8'h00;
    end else begin
      c_q <= o_clk_100k;
      s_q <= sref;
      e_q <= o_ref_out_en;
      n_q <= up ? {7'h00, hit} : n_q + {7'h00, hit};
      // skip two periods around a source switch
      if (e_q ^ o_ref_out_en) sw_q <= 2'h2;
      else if (up && sw_q != 2'h0) sw_q <= sw_q - 2'h1;
    end
  end
  // ==========================================================
  // bus handshakes
  sequence wr_taken;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  sequence rd_taken;
    i_s_axi_arvalid && o_s_axi_arready;
  endsequence
  // ==========================================================
  // properties
  prescale_a: assert property (up && sw_q == 2'h0 |-> n_q == 8'h64)
    else $error("prescaler period not 100 reference edges");
  half_fall_a: assert property ($fell(o_clk_100k) |-> ##[0:1] $changed(o_clk_50k))
    else $error("50k clock missed a toggle");
  half_hold_a: assert property (o_clk_100k && $past(o_clk_100k) |-> $stable(o_clk_50k))
    else $error("50k clock moved while 100k high");
  ref_copy_a: assert property (o_ref_out_en && $past(o_ref_out_en) |-> o_ref_out == $past(i_int_ref))
    else $error("reference output not following internal reference");
  ref_off_a: assert property (!o_ref_out_en |-> !o_ref_out)
    else $error("reference output driven while external");
  gate_edge_a: assert property ($rose(o_gate) |-> o_clk_100k && !$past(o_clk_100k, 2))
    else $error("gate opened off a 100k edge");
  wr_answer_a: assert property (wr_taken |-> ##2 o_s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (rd_taken |=> o_s_axi_rvalid)
    else $error("read data late");
  b_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped early");
  wr_busy_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write channels ready during response");
endmodule // ccg_gate_gen_asserts

bind ccg_gate_gen ccg_gate_gen_asserts chk_u (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_int_ref(i_int_ref), .i_ext_ref(i_ext_ref),
  .i_s_axi_awvalid(i_s_axi_awvalid), .i_s_axi_wvalid(i_s_axi_wvalid), .i_s_axi_bready(i_s_axi_bready),
  .i_s_axi_arvalid(i_s_axi_arvalid), .o_ref_out(o_ref_out), .o_ref_out_en(o_ref_out_en),
  .o_clk_100k(o_clk_100k), .o_clk_50k(o_clk_50k), .o_gate(o_gate), .o_s_axi_awready(o_s_axi_awready),
  .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bvalid(o_s_axi_bvalid), .o_s_axi_arready(o_s_axi_arready),
  .o_s_axi_rvalid(o_s_axi_rvalid), .o_s_axi_bresp(o_s_axi_bresp));
`default_nettype wire

// ---- tb/ccg_far_side.sv ----
// reference sources and count chain model facing the gate generator
`timescale 1ns/100ps
`default_nettype none
module ccg_far_side (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // from the gate generator
  input wire logic i_clk_100k,
  input wire logic i_gate,
  // references and gate width in 100 kHz ticks
  output var logic o_int_ref,
  output var logic o_ext_ref,
  output var logic [16:0] o_width
);
  logic c_q, g_q, ph_q;
  // internal toggles every clock, external every second clock
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_int_ref <= 1'b0;
      o_ext_ref <= 1'b0;
      ph_q <= 1'b0;
      c_q <= 1'b0;
      g_q <= 1'b0;
      o_width <= 17'h00000;
    end else begin
      o_int_ref <= ~o_int_ref;
      ph_q <= ~ph_q;
      if (ph_q) o_ext_ref <= ~o_ext_ref;
      c_q <= i_clk_100k;
      g_q <= i_gate;
      if (i_gate && !g_q) o_width <= {16'h0000, i_clk_100k & ~c_q};
      else if (i_gate && i_clk_100k && !c_q) o_width <= o_width + 17'h00001;
    end
  end
endmodule // ccg_far_side
`default_nettype wire

// ---- tb/tb_ccg_gate_gen.sv ----
// self-checking bench for the counter gate generator
`timescale 1ns/100ps
`default_nettype none
`include "ccg_regs.vh"
module tb_ccg_gate_gen;
  typedef struct packed {logic [31:0] ctrl; logic [16:0] ratio; logic en;} ccg_row_t;
  ccg_row_t rows [4] = '{'{32'h00000003, `CCG_RATIO_100US, 1'b1},
    '{32'h00000005, `CCG_RATIO_1MS, 1'b1}, '{32'h00000001, `CCG_RATIO_100US, 1'b1},
    '{32'h00000002, `CCG_RATIO_100US, 1'b0}};
  // when set, bready is raised only after bvalid is seen
  logic b_late = 1'b0;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
  logic [31:0] w_d = 32'h00000000;
  wire int_ref, ext_ref, ref_out, ref_en, c100, c50, gate, awrdy, wrdy, bv, arrdy, rv;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [16:0] width;
  int bad_count = 0;
  int total_checks = 0;
  always #10 i_clk = ~i_clk;
  ccg_gate_gen dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_int_ref(int_ref), .i_ext_ref(ext_ref),
    .o_ref_out(ref_out), .o_ref_out_en(ref_en), .o_clk_100k(c100), .o_clk_50k(c50), .o_gate(gate),
    .i_s_axi_awvalid(aw_v), .o_s_axi_awready(awrdy), .i_s_axi_awaddr(aw_a), .i_s_axi_awprot(3'h0),
    .i_s_axi_wvalid(w_v), .o_s_axi_wready(wrdy), .i_s_axi_wdata(w_d), .i_s_axi_wstrb(4'hF),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(b_r), .o_s_axi_bresp(bresp), .i_s_axi_arvalid(ar_v),
    .o_s_axi_arready(arrdy), .i_s_axi_araddr(ar_a), .i_s_axi_arprot(3'h0), .o_s_axi_rvalid(rv),
    .i_s_axi_rready(r_r), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp));
  ccg_far_side far_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clk_100k(c100), .i_gate(gate),
    .o_int_ref(int_ref), .o_ext_ref(ext_ref), .o_width(width));
  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    aw_v <= 1'b1;
    aw_a <= a;
    w_v <= 1'b1;
    w_d <= d;
    b_r <= !b_late;
    do begin
      @(posedge i_clk);
      if (aw_v && awrdy) aw_v <= 1'b0;
      if (w_v && wrdy) w_v <= 1'b0;
      if (bv === 1'b1 && b_r !== 1'b1) b_r <= 1'b1;
    end while (!(bv === 1'b1 && b_r === 1'b1));
    r = bresp;
    b_r <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    ar_v <= 1'b1;
    ar_a <= a;
    r_r <= 1'b1;
    do begin
      @(posedge i_clk);
      if (ar_v && arrdy) ar_v <= 1'b0;
    end while (rv !== 1'b1);
    d = rdata;
    r = rresp;
    r_r <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      do @(posedge i_clk); while (c100 !== 1'b0);
      do @(posedge i_clk); while (c100 !== 1'b1);
    end
    @(negedge i_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #1500000;
    bad_count++;
    tally_and_finish();
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] d, d0;
    logic [1:0] r;
    int n;
    repeat (8) @(posedge i_clk);
    chk("reset outputs", {ref_out, ref_en, c100, c50, gate, awrdy, wrdy, arrdy, bv, rv}, 10'h01C);
    i_sys_rst <= 1'b0;
    rd(`CCG_OFS_CTRL, d, r);
    chk("ctrl reset", d, `CCG_CTRL_RESET);
    foreach (rows[i]) begin
      wr(`CCG_OFS_CTRL, rows[i].ctrl, r);
      wr(`CCG_OFS_CMD, 32'h00000001, r);
      tick(2);
      rd(`CCG_OFS_STATUS, d, r);
      chk("status after init", {26'h0, d[5:0]}, 32'h00000004);
      wr(`CCG_OFS_CMD, 32'h00000002, r);
      n = 0;
      while (gate !== 1'b1 && n < 4) begin
        tick(1);
        n++;
      end
      chk("ticks to open", 32'(n), 32'h00000002);
      tick(int'(rows[i].ratio) / 2 - 2);
      rd(`CCG_OFS_STATUS, d, r);
      chk("status before half", {28'h0, d[3:0]}, 32'h00000003);
      tick(2);
      rd(`CCG_OFS_STATUS, d, r);
      chk("status past half", {28'h0, d[3:0]}, 32'h0000000B);
      while (gate !== 1'b0) @(negedge i_clk);
      @(negedge i_clk);
      chk("gate width", {15'h0, width}, {15'h0, rows[i].ratio});
      rd(`CCG_OFS_STATUS, d, r);
      chk("status after close", {26'h0, d[5:0]}, 32'h00000024);
      wr(`CCG_OFS_CMD, 32'h00000004, r);
      chk("ref driver enable", {31'h0, ref_en}, {31'h0, rows[i].en});
    end
    rd(8'h10, d, r);
    chk("unmapped read", {r, d[29:0]}, {`CCG_RESP_SLVERR, 30'h0});
    b_late <= 1'b1;
    wr(8'h10, 32'h00000001, r);
    b_late <= 1'b0;
    chk("unmapped write", {30'h0, r}, {30'h0, `CCG_RESP_SLVERR});
    for (int c = 3; c <= 5; c++) begin
      wr(`CCG_OFS_CTRL, 32'(c * 2 + 1), r);
      rd(`CCG_OFS_CTRL, d, r);
      chk("ctrl code readback", d, 32'(c * 2 + 1));
    end
    rd(`CCG_OFS_CMD, d, r);
    chk("cmd reads zero", d, 32'h00000000);
    // soft reset in the middle of an open gate
    wr(`CCG_OFS_CTRL, 32'h00000005, r);
    wr(`CCG_OFS_CMD, 32'h00000001, r);
    tick(2);
    wr(`CCG_OFS_CMD, 32'h00000002, r);
    tick(4);
    chk("gate open", {31'h0, gate}, 32'h00000001);
    wr(`CCG_OFS_CMD, 32'h00000008, r);
    @(negedge i_clk);
    chk("gate after soft reset", {31'h0, gate}, 32'h00000000);
    rd(`CCG_OFS_STATUS, d, r);
    chk("status after soft reset", {26'h0, d[5:0]}, 32'h00000000);
    rd(`CCG_OFS_COUNT, d0, r);
    tick(1);
    rd(`CCG_OFS_COUNT, d, r);
    chk("divider free runs", {31'h0, d !== d0}, 32'h00000001);
    tick(2);
    chk("gate stays closed", {31'h0, gate}, 32'h00000000);
    tally_and_finish();
  end
endmodule // tb_ccg_gate_gen
`default_nettype wire
